// ---- rtl/scspi_pkg.sv ----
// Constants and types shared by the serial controller SPI core
//--------------------------------------------------------------------------
// Behaviour
// - Data register write pushes one transmit byte
// - Data read pops receive byte, clears overrun
// - First instance UART mode updates error flags
// - Master starts on queued data or receive room
// - Role bit selects master or slave
// - Slave underrun sends busy token or repeat
// - Repeat bit applies only when transmitter idle
// - Bit order selects MSB or LSB first
// - Phase selects first or second sample edge
// - Polarity selects rising or falling leading edge
// - Idle flag: FIFO empty, serializer done
// - Space flag: transmit FIFO not full
// - Valid flag: receive FIFO not empty
// - Overrun set on full receive, held until read
// - Rate is base over linear plus one times power of two
// - Exponent field is four bits
//--------------------------------------------------------------------------
package scspi_pkg;

    // Clocking of the serial clock prescaler
    localparam int unsigned CLK_MHZ    = 40;
    localparam int unsigned BASE_MHZ   = 12;
    localparam int unsigned HALF_MHZ   = 2 * BASE_MHZ;
    localparam logic [5:0]  ACC_STEP   = 6'(HALF_MHZ);
    localparam logic [5:0]  ACC_MOD    = 6'(CLK_MHZ);

    // Register offsets, second and first instance
    localparam logic [15:0] C2_DATA    = 16'hc03c;
    localparam logic [15:0] C2_STAT    = 16'hc040;
    localparam logic [15:0] C2_CFG     = 16'hc058;
    localparam logic [15:0] C2_LIN     = 16'hc060;
    localparam logic [15:0] C2_EXP     = 16'hc064;
    localparam logic [15:0] C2_IST     = 16'hc068;
    localparam logic [15:0] C2_IMSK    = 16'hc06c;
    localparam logic [15:0] C1_DATA    = 16'hc83c;
    localparam logic [15:0] C1_STAT    = 16'hc840;
    localparam logic [15:0] C1_CFG     = 16'hc858;
    localparam logic [15:0] C1_LIN     = 16'hc860;
    localparam logic [15:0] C1_EXP     = 16'hc864;
    localparam logic [15:0] C1_IST     = 16'hc868;
    localparam logic [15:0] C1_IMSK    = 16'hc86c;

    // Status bit positions
    localparam int unsigned ST_RXOVF   = 0;
    localparam int unsigned ST_RXVAL   = 1;
    localparam int unsigned ST_TXFREE  = 2;
    localparam int unsigned ST_TXIDLE  = 3;

    // Interrupt event bits
    localparam int unsigned IRQ_W      = 5;
    localparam int unsigned EV_RXVAL   = 0;
    localparam int unsigned EV_TXFREE  = 1;
    localparam int unsigned EV_TXIDLE  = 2;
    localparam int unsigned EV_RXOVF   = 3;
    localparam int unsigned EV_TXUND   = 4;

    // Fifo and byte geometry, reset values
    localparam int unsigned FIFO_AW    = 2;
    localparam logic [2:0]  FIFO_DEPTH = 3'h4;
    localparam logic [7:0]  BUSY_TOKEN = 8'hff;
    localparam logic [3:0]  BIT_COUNT  = 4'h8;
    localparam logic [3:0]  LAST_HALF  = 4'hf;
    localparam logic [31:0] RESET_VAL  = 32'h0000_0000;

    typedef struct packed {
        logic rxdrv;
        logic mst;
        logic rpt;
        logic ord;
        logic pha;
        logic pol;
    } scspi_cfg_t;

    typedef struct packed {
        logic       par;
        logic       frm;
        logic [7:0] data;
    } scspi_rxent_t;

    typedef enum logic [2:0] {
        R_NONE, R_DATA, R_STAT, R_CFG, R_LIN, R_EXP, R_IST, R_IMSK
    } scspi_reg_t;

endpackage

// ---- rtl/scspi_core.sv ----
// SPI core of one serial controller instance with byte FIFOs
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module scspi_core #(
    parameter bit FIRST_INST = 1'b1
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [15:0] bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_we,
    input  wire logic        bus_re,
    output logic      [31:0] bus_rdata_q,
    output logic             irq_q,
    input  wire logic        uart_mode,
    input  wire logic        uart_par_in,
    input  wire logic        uart_frm_in,
    output logic             uart_par_err_q,
    output logic             uart_frm_err_q,
    input  wire logic        spi_sck_in,
    output logic             spi_sck_q,
    output logic             spi_sck_oe_q,
    input  wire logic        spi_din,
    output logic             spi_dout_q,
    output logic             spi_dout_oe_q,
    input  wire logic        spi_sel_n
);

    //----------------------------------------------------------------------
    // Register decode
    //----------------------------------------------------------------------
    function automatic scspi_pkg::scspi_reg_t reg_dec(input logic [15:0] a);
        scspi_pkg::scspi_reg_t r;
        r = scspi_pkg::R_NONE;
        if (a == (FIRST_INST ? scspi_pkg::C1_DATA : scspi_pkg::C2_DATA))
            r = scspi_pkg::R_DATA;
        if (a == (FIRST_INST ? scspi_pkg::C1_STAT : scspi_pkg::C2_STAT))
            r = scspi_pkg::R_STAT;
        if (a == (FIRST_INST ? scspi_pkg::C1_CFG : scspi_pkg::C2_CFG))
            r = scspi_pkg::R_CFG;
        if (a == (FIRST_INST ? scspi_pkg::C1_LIN : scspi_pkg::C2_LIN))
            r = scspi_pkg::R_LIN;
        if (a == (FIRST_INST ? scspi_pkg::C1_EXP : scspi_pkg::C2_EXP))
            r = scspi_pkg::R_EXP;
        if (a == (FIRST_INST ? scspi_pkg::C1_IST : scspi_pkg::C2_IST))
            r = scspi_pkg::R_IST;
        if (a == (FIRST_INST ? scspi_pkg::C1_IMSK : scspi_pkg::C2_IMSK))
            r = scspi_pkg::R_IMSK;
        return r;
    endfunction

    // Bit presented on the data line for the given order
    function automatic logic out_bit(input logic [7:0] s, input logic ord);
        return ord ? s[0] : s[7];
    endfunction

    function automatic logic [7:0] shift_tx(input logic [7:0] s,
                                            input logic ord);
        return ord ? {1'b0, s[7:1]} : {s[6:0], 1'b0};
    endfunction

    scspi_pkg::scspi_reg_t sel;
    scspi_pkg::scspi_cfg_t cfg_q;
    logic [3:0]                 lin_q;
    logic [3:0]                 exp_q;
    logic [scspi_pkg::IRQ_W-1:0] imask_q;
    logic [scspi_pkg::IRQ_W-1:0] istat_q;
    logic [scspi_pkg::IRQ_W-1:0] ev;
    logic        wr_data;
    logic        rd_data;
    logic        rd_stat;

    assign sel     = reg_dec(bus_addr);
    assign wr_data = bus_we && (sel == scspi_pkg::R_DATA);
    assign rd_data = bus_re && (sel == scspi_pkg::R_DATA);
    assign rd_stat = bus_re && (sel == scspi_pkg::R_STAT);

    //----------------------------------------------------------------------
    // Fifos
    //----------------------------------------------------------------------
    logic [7:0]                 tx_mem [2**scspi_pkg::FIFO_AW];
    scspi_pkg::scspi_rxent_t    rx_mem [2**scspi_pkg::FIFO_AW];
    logic [2:0]  tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
    logic [2:0]  tx_cnt, rx_cnt;
    logic        tx_full, tx_empty, rx_full, rx_empty;
    logic        tx_push, tx_pop, rx_push, rx_pop;
    logic [7:0]  tx_head;
    scspi_pkg::scspi_rxent_t rx_head, rx_next;

    assign tx_cnt   = tx_wp_q - tx_rp_q;
    assign rx_cnt   = rx_wp_q - rx_rp_q;
    assign tx_full  = (tx_cnt == scspi_pkg::FIFO_DEPTH);
    assign rx_full  = (rx_cnt == scspi_pkg::FIFO_DEPTH);
    assign tx_empty = (tx_cnt == 3'h0);
    assign rx_empty = (rx_cnt == 3'h0);
    assign tx_head  = tx_mem[tx_rp_q[scspi_pkg::FIFO_AW-1:0]];
    assign rx_head  = rx_mem[rx_rp_q[scspi_pkg::FIFO_AW-1:0]];
    assign rx_next  = rx_mem[2'(rx_rp_q + 3'h1)];
    assign tx_push  = wr_data && !tx_full;
    assign rx_pop   = rd_data && !rx_empty;

    // Transmit fifo storage and pointers
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_wp_q <= 3'h0;
            tx_rp_q <= 3'h0;
        end else begin
            if (tx_push) begin
                tx_mem[tx_wp_q[scspi_pkg::FIFO_AW-1:0]] <= bus_wdata[7:0];
                tx_wp_q <= tx_wp_q + 3'h1;
            end
            if (tx_pop)
                tx_rp_q <= tx_rp_q + 3'h1;
        end
    end

    // Receive fifo storage and pointers
    logic [7:0] rx_byte;
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_wp_q <= 3'h0;
            rx_rp_q <= 3'h0;
        end else begin
            if (rx_push) begin
                rx_mem[rx_wp_q[scspi_pkg::FIFO_AW-1:0]] <=
                    '{par: uart_par_in, frm: uart_frm_in, data: rx_byte};
                rx_wp_q <= rx_wp_q + 3'h1;
            end
            if (rx_pop)
                rx_rp_q <= rx_rp_q + 3'h1;
        end
    end

    //----------------------------------------------------------------------
    // Configuration registers
    //----------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_q   <= scspi_pkg::scspi_cfg_t'(scspi_pkg::RESET_VAL[5:0]);
            lin_q   <= scspi_pkg::RESET_VAL[3:0];
            exp_q   <= scspi_pkg::RESET_VAL[3:0];
            imask_q <= scspi_pkg::RESET_VAL[scspi_pkg::IRQ_W-1:0];
        end else if (bus_we) begin
            if (sel == scspi_pkg::R_CFG)
                cfg_q <= scspi_pkg::scspi_cfg_t'(bus_wdata[5:0]);
            if (sel == scspi_pkg::R_LIN)
                lin_q <= bus_wdata[3:0];
            if (sel == scspi_pkg::R_EXP)
                exp_q <= bus_wdata[3:0];
            if (sel == scspi_pkg::R_IMSK)
                imask_q <= bus_wdata[scspi_pkg::IRQ_W-1:0];
        end
    end

    //----------------------------------------------------------------------
    // Serial clock prescaler
    //----------------------------------------------------------------------
    logic [5:0]  acc_q;
    logic [6:0]  acc_sum;
    logic        base_tick;
    logic [3:0]  lin_cnt_q;
    logic [15:0] exp_cnt_q;
    logic [15:0] exp_max;
    logic        half_tick;
    logic        busy_q;

    assign acc_sum   = {1'b0, acc_q} + {1'b0, scspi_pkg::ACC_STEP};
    assign base_tick = (acc_sum >= {1'b0, scspi_pkg::ACC_MOD});
    assign exp_max   = 16'((17'h1 << exp_q) - 17'h1);
    assign half_tick = base_tick && (lin_cnt_q == lin_q)
                       && (exp_cnt_q == exp_max);

    // Fractional base: half-period ticks at twice the base rate
    always_ff @(posedge clk) begin
        if (reset)
            acc_q <= 6'h0;
        else if (base_tick)
            acc_q <= 6'(acc_sum - {1'b0, scspi_pkg::ACC_MOD});
        else
            acc_q <= acc_sum[5:0];
    end

    // Linear then exponential divide, restarted at each byte
    always_ff @(posedge clk) begin
        if (reset || !busy_q) begin
            lin_cnt_q <= 4'h0;
            exp_cnt_q <= 16'h0;
        end else if (base_tick) begin
            if (lin_cnt_q == lin_q) begin
                lin_cnt_q <= 4'h0;
                exp_cnt_q <= (exp_cnt_q == exp_max) ? 16'h0
                                                    : exp_cnt_q + 16'h1;
            end else begin
                lin_cnt_q <= lin_cnt_q + 4'h1;
            end
        end
    end

    //----------------------------------------------------------------------
    // Shift engine
    //----------------------------------------------------------------------
    logic [7:0] tx_sh_q, rx_sh_q, last_tx_q, load_byte;
    logic [3:0] drv_q, smp_q, half_q;
    logic       sck_prev_q, rpt_eff_q;
    logic       start_ok, load, underrun, tx_idle;
    logic       edge_ev, lead_ev, trail_ev, drive_ev, samp_ev, byte_done;
    logic       slave_off, master_end;

    assign tx_idle  = tx_empty && !busy_q;
    assign start_ok = cfg_q.mst ? (cfg_q.rxdrv ? !rx_full : !tx_empty)
                                : !spi_sel_n;
    assign load     = !busy_q && start_ok;
    assign tx_pop   = load && !tx_empty;
    assign underrun = load && tx_empty && !cfg_q.mst;
    assign load_byte = !tx_empty ? tx_head
                     : (cfg_q.mst || !rpt_eff_q) ? scspi_pkg::BUSY_TOKEN
                     : last_tx_q;
    assign slave_off = !cfg_q.mst && spi_sel_n;

    // Master edges from the prescaler, slave edges from the pin
    assign edge_ev  = busy_q && (cfg_q.mst ? half_tick
                      : (!spi_sel_n && (spi_sck_in != sck_prev_q)));
    assign lead_ev  = edge_ev && (cfg_q.mst ? !half_q[0]
                      : (spi_sck_in != cfg_q.pol));
    assign trail_ev = edge_ev && !lead_ev;
    assign drive_ev = (cfg_q.pha ? lead_ev : trail_ev)
                      && (drv_q == smp_q) && (drv_q < scspi_pkg::BIT_COUNT);
    assign samp_ev  = (cfg_q.pha ? trail_ev : lead_ev)
                      && (smp_q < drv_q);
    assign byte_done  = samp_ev && (smp_q == scspi_pkg::BIT_COUNT - 4'h1);
    assign master_end = cfg_q.mst && half_tick && busy_q
                        && (half_q == scspi_pkg::LAST_HALF);
    assign rx_byte  = cfg_q.ord ? {spi_din, rx_sh_q[7:1]}
                                : {rx_sh_q[6:0], spi_din};
    assign rx_push  = byte_done && !rx_full;

    // Byte framing and bit counters
    always_ff @(posedge clk) begin
        if (reset || slave_off) begin
            busy_q <= 1'b0;
            drv_q  <= 4'h0;
            smp_q  <= 4'h0;
            half_q <= 4'h0;
        end else if (load) begin
            busy_q <= 1'b1;
            drv_q  <= cfg_q.pha ? 4'h0 : 4'h1;
            smp_q  <= 4'h0;
            half_q <= 4'h0;
        end else begin
            if (drive_ev)
                drv_q <= drv_q + 4'h1;
            if (samp_ev)
                smp_q <= smp_q + 4'h1;
            if (cfg_q.mst && half_tick && busy_q)
                half_q <= half_q + 4'h1;
            if (master_end || (!cfg_q.mst && byte_done))
                busy_q <= 1'b0;
        end
    end

    // Transmit serializer and data line
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_sh_q    <= 8'h00;
            spi_dout_q <= 1'b0;
        end else if (load) begin
            tx_sh_q    <= cfg_q.pha ? load_byte
                                    : shift_tx(load_byte, cfg_q.ord);
            if (!cfg_q.pha)
                spi_dout_q <= out_bit(load_byte, cfg_q.ord);
        end else if (drive_ev) begin
            spi_dout_q <= out_bit(tx_sh_q, cfg_q.ord);
            tx_sh_q    <= shift_tx(tx_sh_q, cfg_q.ord);
        end
    end

    // Receive deserializer
    always_ff @(posedge clk) begin
        if (reset)
            rx_sh_q <= 8'h00;
        else if (samp_ev)
            rx_sh_q <= rx_byte;
    end

    // Last byte sent and the repeat mode latched while idle
    always_ff @(posedge clk) begin
        if (reset) begin
            last_tx_q <= 8'h00;
            rpt_eff_q <= 1'b0;
        end else begin
            if (load)
                last_tx_q <= load_byte;
            if (tx_idle)
                rpt_eff_q <= cfg_q.rpt;
        end
    end

    // Serial clock and output enables
    always_ff @(posedge clk) begin
        if (reset) begin
            spi_sck_q     <= 1'b0;
            spi_sck_oe_q  <= 1'b0;
            spi_dout_oe_q <= 1'b0;
            sck_prev_q    <= 1'b0;
        end else begin
            sck_prev_q    <= spi_sck_in;
            spi_sck_oe_q  <= cfg_q.mst;
            spi_dout_oe_q <= cfg_q.mst || !spi_sel_n;
            if (!cfg_q.mst || !busy_q)
                spi_sck_q <= cfg_q.pol;
            else if (half_tick)
                spi_sck_q <= ~spi_sck_q;
        end
    end

    //----------------------------------------------------------------------
    // Status, interrupts and read data
    //----------------------------------------------------------------------
    logic rxovf_q, idle_prev_q;

    // Overrun flag, a new overrun wins over the read clear
    always_ff @(posedge clk) begin
        if (reset)
            rxovf_q <= 1'b0;
        else if (byte_done && rx_full)
            rxovf_q <= 1'b1;
        else if (rd_data)
            rxovf_q <= 1'b0;
    end

    // Error flags of the byte now at the head of the fifo
    always_ff @(posedge clk) begin
        if (reset) begin
            uart_par_err_q <= 1'b0;
            uart_frm_err_q <= 1'b0;
        end else if (FIRST_INST && uart_mode && rd_data) begin
            uart_par_err_q <= (rx_cnt > 3'h1) && rx_next.par;
            uart_frm_err_q <= (rx_cnt > 3'h1) && rx_next.frm;
        end
    end

    assign ev[scspi_pkg::EV_RXVAL]  = rx_push;
    assign ev[scspi_pkg::EV_TXFREE] = tx_pop;
    assign ev[scspi_pkg::EV_TXIDLE] = tx_idle && !idle_prev_q;
    assign ev[scspi_pkg::EV_RXOVF]  = byte_done && rx_full;
    assign ev[scspi_pkg::EV_TXUND]  = underrun;

    // Sticky events, read clears, a new event wins
    always_ff @(posedge clk) begin
        if (reset) begin
            istat_q     <= '0;
            idle_prev_q <= 1'b1;
            irq_q       <= 1'b0;
        end else begin
            idle_prev_q <= tx_idle;
            if (bus_re && (sel == scspi_pkg::R_IST))
                istat_q <= ev;
            else
                istat_q <= istat_q | ev;
            irq_q <= |(istat_q & imask_q);
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset || !bus_re) begin
            bus_rdata_q <= scspi_pkg::RESET_VAL;
        end else begin
            bus_rdata_q <= 32'h0;
            unique case (sel)
                scspi_pkg::R_DATA: bus_rdata_q[7:0] <= rx_head.data;
                scspi_pkg::R_STAT: begin
                    bus_rdata_q[scspi_pkg::ST_TXIDLE] <= tx_idle;
                    bus_rdata_q[scspi_pkg::ST_TXFREE] <= !tx_full;
                    bus_rdata_q[scspi_pkg::ST_RXVAL]  <= !rx_empty;
                    bus_rdata_q[scspi_pkg::ST_RXOVF]  <= rxovf_q;
                end
                scspi_pkg::R_CFG:  bus_rdata_q[5:0] <= cfg_q;
                scspi_pkg::R_LIN:  bus_rdata_q[3:0] <= lin_q;
                scspi_pkg::R_EXP:  bus_rdata_q[3:0] <= exp_q;
                scspi_pkg::R_IST:  bus_rdata_q[scspi_pkg::IRQ_W-1:0] <= istat_q;
                scspi_pkg::R_IMSK: bus_rdata_q[scspi_pkg::IRQ_W-1:0] <= imask_q;
                scspi_pkg::R_NONE: bus_rdata_q <= 32'h0;
            endcase
        end
    end

    //----------------------------------------------------------------------
    // Checks
    //----------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_master_idle;
        cfg_q.mst && !busy_q && !half_tick;
    endsequence
    sequence s_sample_slot;
        samp_ev && cfg_q.pha;
    endsequence

    chk_tx_push_count: assert property (
        tx_push && !tx_pop |=> tx_cnt == $past(tx_cnt) + 3'h1)
        else $error("transmit push did not add one byte");
    chk_rx_pop_data: assert property (
        rx_pop && !rx_push |=> rx_cnt == $past(rx_cnt) - 3'h1
                               && bus_rdata_q[7:0] == $past(rx_head.data))
        else $error("receive pop wrong");
    chk_ovf_clear: assert property (
        rd_data && !(byte_done && rx_full) |=> !rxovf_q)
        else $error("overrun not cleared by data read");
    chk_ovf_set: assert property (
        byte_done && rx_full |=> rxovf_q && rx_cnt == scspi_pkg::FIFO_DEPTH
                                 - 3'($past(rx_pop)))
        else $error("overrun not set");
    chk_start_tx: assert property (
        cfg_q.mst && !cfg_q.rxdrv && !busy_q && !tx_empty |=> busy_q)
        else $error("master did not start");
    chk_role_sck: assert property (
        $changed(cfg_q.mst) |=> spi_sck_oe_q == cfg_q.mst)
        else $error("clock enable does not follow role");
    chk_underrun_tok: assert property (
        underrun && !rpt_eff_q && cfg_q.pha |=> tx_sh_q == scspi_pkg::BUSY_TOKEN)
        else $error("busy token not loaded");
    chk_rpt_hold: assert property (
        !tx_idle |=> rpt_eff_q == $past(rpt_eff_q))
        else $error("repeat mode changed while busy");
    chk_order_lsb: assert property (
        drive_ev && !load && cfg_q.ord |=> spi_dout_q == $past(tx_sh_q[0]))
        else $error("lsb first order broken");
    chk_phase_edge: assert property (
        s_sample_slot |-> trail_ev)
        else $error("phase one sampled on leading edge");
    chk_idle_flag: assert property (
        rd_stat |=> bus_rdata_q[scspi_pkg::ST_TXIDLE] == $past(tx_idle)
                    && bus_rdata_q[scspi_pkg::ST_TXFREE] == !$past(tx_full))
        else $error("status flags wrong");
    chk_sck_idle: assert property (
        s_master_idle ##1 s_master_idle |-> spi_sck_q == $past(cfg_q.pol))
        else $error("master clock not idle");
    chk_half_tick: assert property (
        half_tick |-> base_tick && lin_cnt_q == lin_q && exp_cnt_q == exp_max)
        else $error("prescaler tick misplaced");

endmodule // scspi_core

// ---- tb/scspi_peer_model.sv ----
// SPI peer on the serial side: mode 0, MSB first, fixed reply byte
`timescale 1ns/1ps
module scspi_peer_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        sck,
    input  wire logic        mosi,
    input  wire logic [7:0]  reply,
    output logic             miso,
    output logic [7:0]       got,
    output int unsigned      nbytes
);
    logic       sck_p;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    // Sample on rising leading edge, shift on falling edge
    always_ff @(posedge clk) begin
        if (reset) begin
            sck_p  <= 1'b0;
            bit_q  <= 3'h0;
            nbytes <= 0;
            got    <= 8'h00;
        end else begin
            sck_p <= sck;
            if (sck && !sck_p) begin
                sh_q <= {sh_q[6:0], mosi};
                if (bit_q == 3'h7) begin
                    got    <= {sh_q[6:0], mosi};
                    nbytes <= nbytes + 1;
                end
            end
            if (!sck && sck_p) bit_q <= bit_q + 3'h1;
        end
    end
    assign miso = reply[3'h7 - bit_q];
endmodule // scspi_peer_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the SPI core in master role
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, reset = 1, we = 0, re = 0, re_seen = 0;
    logic irq, sck, sck_oe, dout, dout_oe, miso, par, frm;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wdata = 32'h0, rdata, rnd = 32'h49140188;
    logic [7:0]  reply = 8'h00, got, tx;
    logic [31:0] expq[$];
    int unsigned nb, n_exp = 0, fail_count = 0, checks = 0, cyc = 0;
    always #12.5 clk = ~clk;
    scspi_core scspi_core_inst (.clk(clk), .reset(reset), .bus_addr(addr),
        .bus_wdata(wdata), .bus_we(we), .bus_re(re), .bus_rdata_q(rdata),
        .irq_q(irq), .uart_mode(1'b0), .uart_par_in(1'b0),
        .uart_frm_in(1'b0), .uart_par_err_q(par), .uart_frm_err_q(frm),
        .spi_sck_in(1'b0), .spi_sck_q(sck), .spi_sck_oe_q(sck_oe),
        .spi_din(miso), .spi_dout_q(dout), .spi_dout_oe_q(dout_oe),
        .spi_sel_n(1'b1));
    scspi_peer_model scspi_peer_model_inst (.clk(clk), .reset(reset),
        .sck(sck), .mosi(dout), .reply(reply), .miso(miso), .got(got),
        .nbytes(nb));
    function automatic logic [7:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd[7:0];
    endfunction
    function automatic logic [7:0] rev8(logic [7:0] x);
        return {<<{x}};
    endfunction
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        if (fail_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(logic [15:0] a, logic [31:0] d);
        addr  <= a;
        wdata <= d;
        we    <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(logic [15:0] a, logic [31:0] e);
        expq.push_back(e);
        addr <= a;
        re   <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_bytes();
        for (int i = 0; i < 3000 && nb != n_exp; i++) @(posedge clk);
        repeat (8) @(posedge clk);
    endtask
    // Read data monitor and cycle ceiling
    always @(posedge clk) begin
        if (re_seen) check("rdata", rdata, expq.pop_front());
        re_seen <= re;
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(scspi_pkg::C1_STAT, 32'hc);
        rd(scspi_pkg::C1_CFG, 32'h0);
        rd(16'hc8f0, 32'h0);
        wr(scspi_pkg::C1_EXP, 32'h1f);
        rd(scspi_pkg::C1_EXP, 32'hf);
        wr(scspi_pkg::C1_EXP, 32'h0);
        wr(scspi_pkg::C1_LIN, 32'h1);
        rd(scspi_pkg::C1_LIN, 32'h1);
        wr(scspi_pkg::C1_IMSK, 32'h8);
        for (int o = 0; o < 2; o++) begin
            tx = xs();
            reply <= xs();
            wr(scspi_pkg::C1_CFG, 32'h10 | (o << 2));
            wr(scspi_pkg::C1_DATA, {24'h0, tx});
            n_exp++;
            wait_bytes();
            check("peer", got, o ? rev8(tx) : tx);
            rd(scspi_pkg::C1_STAT, 32'he);
            rd(scspi_pkg::C1_DATA, o ? rev8(reply) : reply);
            rd(scspi_pkg::C1_STAT, 32'hc);
        end
        wr(scspi_pkg::C1_CFG, 32'h10);
        for (int i = 0; i < 5; i++) wr(scspi_pkg::C1_DATA, {24'h0, xs()});
        n_exp += 5;
        wait_bytes();
        rd(scspi_pkg::C1_STAT, 32'hf);
        check("irq", irq, 1'b1);
        rd(scspi_pkg::C1_IST, 32'hf);
        // Interrupt line lags the cleared status by one cycle
        @(posedge clk);
        check("irq", irq, 1'b0);
        rd(scspi_pkg::C1_DATA, reply);
        rd(scspi_pkg::C1_STAT, 32'he);
        wr(scspi_pkg::C1_CFG, 32'h30);
        n_exp++;
        wait_bytes();
        check("peer", got, 8'hff);
        check("count", nb, n_exp);
        rd(scspi_pkg::C1_STAT, 32'he);
        conclude();
    end
endmodule // tb_top
